// File: rtl/rxs_writeback.sv
// receive descriptor status writeback sequencer
// timing: the first-fragment write shows two edges after the report edge,
// a multi-buffer frame adds a last-mark write on the edge after that, and
// a discard pulse shows one edge after the report edge
`timescale 1ns/10ps
`include "rxs_params.svh"
module rxs_writeback
    import rxs_pkg::*;
(
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst_b,
    // accept configuration
    input  wire logic  keepErrorFrames,
    input  wire logic  keepShortFrames,
    input  wire logic  keepMacControlFrames,
    input  wire logic  keepAllFramesPromiscuous,
    input  wire logic  checkRetained,
    // end of frame strobe from the classifier
    input  wire logic  frameDone,
    // error classes under the error keep bit
    input  wire logic  isOversize,
    input  wire logic  isFragment,
    // size and class conditions with their own keep bits
    input  wire logic  isUndersize,
    input  wire logic  isControl,
    // receive overrun abort, kept whatever the keep bits say
    input  wire logic  isOverrun,
    // more error classes under the error keep bit
    input  wire logic  isSymbolErr,
    input  wire logic  isAlignErr,
    input  wire logic  isChecksumErr,
    // address filter miss, kept only in promiscuous mode or on overrun
    input  wire logic  isAddrMiss,
    // overlong frame, under the error keep bit
    input  wire logic  isJabber,
    // frame spans more than one buffer
    input  wire logic  multiBuffer,
    // descriptor memory write port
    output logic       descWrite,
    output rxs_status_t descStatus,
    // first-fragment qualifier of the write
    output logic       descFirst,
    // pulse for a frame that was not kept
    output logic       frameDiscarded
);
    // classifier result
    rxs_status_t flags;
    logic        keep;
    // sequencer state
    rxs_state_e  state_r;
    rxs_state_e  state_nxt;
    // report captured at the taking edge
    rxs_status_t status_r;
    logic        multi_r;
    // write port registers and their next values
    logic        write_r;
    logic        write_nxt;
    logic        first_r;
    logic        first_nxt;
    rxs_status_t statusOut_r;
    rxs_status_t statusOut_nxt;
    // discard pulse
    logic        drop_r;

    // a report is taken only while no write is pending; one that lands
    // in the busy window is dropped silently, so the classifier has to
    // space its reports by the length of the write sequence
    function automatic logic reportTaken(input rxs_state_e st,
                                         input logic       done);
        return (st == RXS_IDLE) && done;
    endfunction : reportTaken

    // frame classification; purely combinational, so keep and the flag
    // word are judged from the inputs present at the strobe edge
    rxs_classify u_classify (
        .keepErrorFrames          (keepErrorFrames),
        .keepShortFrames          (keepShortFrames),
        .keepMacControlFrames     (keepMacControlFrames),
        .keepAllFramesPromiscuous (keepAllFramesPromiscuous),
        .checkRetained            (checkRetained),
        .isOversize               (isOversize),
        .isFragment               (isFragment),
        .isUndersize              (isUndersize),
        .isControl                (isControl),
        .isOverrun                (isOverrun),
        .isSymbolErr              (isSymbolErr),
        .isAlignErr               (isAlignErr),
        .isChecksumErr            (isChecksumErr),
        .isAddrMiss               (isAddrMiss),
        .isJabber                 (isJabber),
        .flags                    (flags),
        .keep                     (keep)
    );

    // next state: first descriptor, then one tail write if multi-buffer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RXS_IDLE: begin
                // an unkept report leaves the sequencer idle
                if (frameDone && keep) begin
                    state_nxt = RXS_FIRST;
                end
            end
            RXS_FIRST: begin
                // a multi-buffer frame still owes its last-mark write
                if (multi_r) begin
                    state_nxt = RXS_MORE;
                end else begin
                    state_nxt = RXS_IDLE;
                end
            end
            default: begin
                state_nxt = RXS_IDLE;
            end
        endcase
    end

    // state register; reset leaves the sequencer idle for the first report
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= RXS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // capture the flag word of a kept frame; the condition inputs are only
    // valid with the strobe, so the word is held for the write edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= `RXS_STATUS_ZERO;
        end else if (reportTaken(state_r, frameDone) && keep) begin
            status_r <= flags;
        end
    end

    // capture the buffer layout of a kept frame for the tail write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            multi_r <= 1'b0;
        end else if (reportTaken(state_r, frameDone) && keep) begin
            multi_r <= multiBuffer;
        end
    end

    // next write: the first-fragment word, then for a multi-buffer frame
    // a tail word that carries only the last mark
    always_comb begin
        write_nxt     = 1'b0;
        first_nxt     = 1'b0;
        statusOut_nxt = `RXS_STATUS_ZERO;
        case (state_r)
            RXS_FIRST: begin
                write_nxt     = 1'b1;
                first_nxt     = 1'b1;
                statusOut_nxt = status_r;
                // single buffer carries last mark too
                statusOut_nxt[`RXS_BIT_LAST] = ~multi_r;
            end
            RXS_MORE: begin
                write_nxt = 1'b1;
                statusOut_nxt[`RXS_BIT_LAST] = 1'b1;
            end
            // idle: no write, word stays zero
            default: begin
                write_nxt = 1'b0;
            end
        endcase
    end

    // write port registers; the word drops back to zero between writes so
    // the memory side never latches stale flags on an idle cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            write_r     <= 1'b0;
            first_r     <= 1'b0;
            statusOut_r <= `RXS_STATUS_ZERO;
        end else begin
            write_r     <= write_nxt;
            first_r     <= first_nxt;
            statusOut_r <= statusOut_nxt;
        end
    end

    // discard pulse for unkept frames; a report that arrives while a
    // write is pending is ignored instead
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            drop_r <= 1'b0;
        end else begin
            drop_r <= reportTaken(state_r, frameDone) && !keep;
        end
    end

    // registered outputs to the descriptor memory
    assign descWrite      = write_r;
    assign descStatus     = statusOut_r;
    assign descFirst      = first_r;
    assign frameDiscarded = drop_r;
endmodule : rxs_writeback

// File: rtl/rxs_params.svh
// constants for the receive descriptor status writeback block
`ifndef RXS_PARAMS_SVH
`define RXS_PARAMS_SVH
`define RXS_FLAG_W        12
`define RXS_BIT_FIRST     0
`define RXS_BIT_LAST      1
`define RXS_BIT_OVERSIZE  2
`define RXS_BIT_FRAGMENT  3
`define RXS_BIT_UNDERSIZE 4
`define RXS_BIT_CONTROL   5
`define RXS_BIT_OVERRUN   6
`define RXS_BIT_SYMBOL    7
`define RXS_BIT_ALIGN     8
`define RXS_BIT_CHECKSUM  9
`define RXS_BIT_ADDRMISS  10
`define RXS_BIT_JABBER    11
`define RXS_BIT_CRCKEPT   12
`define RXS_STATUS_W      13
`define RXS_STATUS_ZERO   13'h0000
`endif

// File: rtl/rxs_pkg.sv
// types shared by the receive status writeback block
`include "rxs_params.svh"
package rxs_pkg;
    typedef logic [`RXS_STATUS_W-1:0] rxs_status_t;
    typedef enum logic [1:0] {
        RXS_IDLE,
        RXS_FIRST,
        RXS_MORE
    } rxs_state_e;
endpackage : rxs_pkg

// File: rtl/rxs_classify.sv
// keep or discard decision and first-fragment flag word for one frame
`timescale 1ns/10ps
`include "rxs_params.svh"
module rxs_classify
    import rxs_pkg::*;
(
    // keep configuration
    input  wire logic  keepErrorFrames,
    input  wire logic  keepShortFrames,
    input  wire logic  keepMacControlFrames,
    input  wire logic  keepAllFramesPromiscuous,
    input  wire logic  checkRetained,
    // frame conditions
    input  wire logic  isOversize,
    input  wire logic  isFragment,
    input  wire logic  isUndersize,
    input  wire logic  isControl,
    input  wire logic  isOverrun,
    input  wire logic  isSymbolErr,
    input  wire logic  isAlignErr,
    input  wire logic  isChecksumErr,
    input  wire logic  isAddrMiss,
    input  wire logic  isJabber,
    // result
    output rxs_status_t flags,
    output logic       keep
);
    logic errAny;
    // error classes under the error keep bit
    assign errAny = isOversize | isFragment | isSymbolErr | isAlignErr
                  | isChecksumErr | isJabber;
    assign keep = isOverrun
                | ((~errAny | keepErrorFrames)
                   & (~isUndersize | keepShortFrames)
                   & (~isControl | keepMacControlFrames)
                   & (~isAddrMiss | keepAllFramesPromiscuous));
    // flag word; last mark is added by the sequencer
    always_comb begin
        flags = `RXS_STATUS_ZERO;
        flags[`RXS_BIT_FIRST]     = 1'b1;
        flags[`RXS_BIT_OVERSIZE]  = isOversize;
        flags[`RXS_BIT_FRAGMENT]  = isFragment;
        flags[`RXS_BIT_UNDERSIZE] = isUndersize;
        flags[`RXS_BIT_CONTROL]   = isControl;
        flags[`RXS_BIT_OVERRUN]   = isOverrun;
        flags[`RXS_BIT_SYMBOL]    = isSymbolErr;
        flags[`RXS_BIT_ALIGN]     = isAlignErr;
        flags[`RXS_BIT_CHECKSUM]  = isChecksumErr;
        flags[`RXS_BIT_ADDRMISS]  = isAddrMiss;
        flags[`RXS_BIT_JABBER]    = isJabber;
        flags[`RXS_BIT_CRCKEPT]   = checkRetained;
    end
endmodule : rxs_classify

// File: verification/rxs_writeback_assertions.sv
// checker for the receive status writeback ports
`timescale 1ns/10ps
`include "rxs_params.svh"
module rxs_writeback_assertions
    import rxs_pkg::*;
(
    // clock, reset, keep bits
    input wire logic sys_clk, rst_b, checkRetained, keepErrorFrames,
    input wire logic keepShortFrames, keepMacControlFrames,
    input wire logic keepAllFramesPromiscuous, frameDone, multiBuffer,
    // frame conditions
    input wire logic isOversize, isFragment, isUndersize, isControl,
    input wire logic isOverrun, isSymbolErr, isAlignErr, isChecksumErr,
    input wire logic isAddrMiss, isJabber,
    // descriptor write port
    input wire logic        descWrite, descFirst, frameDiscarded,
    input wire rxs_status_t descStatus
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [1:0] busyCnt_r;
    wire [9:0] cond = {isJabber, isAddrMiss, isChecksumErr, isAlignErr,
        isSymbolErr, isOverrun, isControl, isUndersize, isFragment, isOversize};
    wire keepIt = isOverrun | ((!(|(cond & 10'h2E3)) | keepErrorFrames)
        & (!isUndersize | keepShortFrames) & (!isControl | keepMacControlFrames)
        & (!isAddrMiss | keepAllFramesPromiscuous));
    wire take = frameDone & (busyCnt_r == 2'h0);
    // busy window after a kept frame
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) busyCnt_r <= 2'h0;
        else if (take & keepIt) busyCnt_r <= multiBuffer ? 2'h2 : 2'h1;
        else if (busyCnt_r != 2'h0) busyCnt_r <= busyCnt_r - 2'h1;
    end
    sequence s_kept; take && keepIt; endsequence
    sequence s_first; descWrite && descFirst && descStatus[0]; endsequence
    property p_discard; take && !keepIt |=> frameDiscarded && !descWrite
        ##1 !descWrite; endproperty
    a_discard: assert property (p_discard)
        else $error("dropped frame wrote status");
    property p_keep; s_kept |=> !frameDiscarded ##1 s_first; endproperty
    a_keep: assert property (p_keep)
        else $error("kept frame lacks first write");
    property p_flags; s_kept |-> ##2 descStatus[11:2] == $past(cond, 2);
    endproperty
    a_flags: assert property (p_flags)
        else $error("flag bits wrong");
    property p_overrun; take && isOverrun |-> ##2 descWrite && descStatus[6];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun frame not flagged");
    property p_crc; s_kept |-> ##2 descStatus[12] == $past(checkRetained, 2);
    endproperty
    a_crc: assert property (p_crc)
        else $error("retained flag wrong");
    property p_single; (s_kept and !multiBuffer) |-> ##2 descStatus[1]
        ##1 !descWrite; endproperty
    a_single: assert property (p_single)
        else $error("single buffer marks wrong");
    property p_multi; (s_kept and multiBuffer) |-> ##2 !descStatus[1]
        ##1 descWrite && !descFirst && descStatus == 13'h0002; endproperty
    a_multi: assert property (p_multi)
        else $error("later descriptor wrong");
    property p_quiet; !descWrite |-> descStatus == 13'h0000 && !descFirst;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("status without write");
endmodule : rxs_writeback_assertions

// File: verification/rxs_desc_mem.sv
// descriptor queue model that records every status write
`timescale 1ns/10ps
module rxs_desc_mem
    import rxs_pkg::*;
(
    // clock and write port
    input  wire logic        sys_clk,
    input  wire logic        descWrite,
    input  wire rxs_status_t descStatus,
    // descriptors written so far
    output logic [7:0]       wrCount = 8'h00
);
    rxs_status_t memWord [0:255] = '{default: 13'h0000};
    // store each status word in the next free descriptor
    always_ff @(posedge sys_clk) begin
        if (descWrite) begin
            memWord[wrCount] <= descStatus;
            wrCount <= wrCount + 8'h01;
        end
    end
endmodule : rxs_desc_mem

// File: verification/rxs_writeback_test.sv
// self-checking bench for the receive status writeback block
`timescale 1ns/10ps
module rxs_writeback_test
    import rxs_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, frameDone = 1'b0;
    logic checkRetained = 1'b0, multiBuffer = 1'b0;
    logic [9:0]  cond = 10'h000;
    logic [3:0]  keepBits = 4'h0;
    logic [7:0]  wrCount;
    logic        descWrite, descFirst, frameDiscarded;
    rxs_status_t descStatus;
    int          n_mismatch = 0, compares = 0, nDisc = 0, nFirst = 0;
    rxs_writeback i_dut (.sys_clk, .rst_b, .checkRetained, .frameDone,
        .keepErrorFrames(keepBits[0]), .keepShortFrames(keepBits[1]),
        .keepMacControlFrames(keepBits[2]),
        .keepAllFramesPromiscuous(keepBits[3]), .isOversize(cond[0]),
        .isFragment(cond[1]), .isUndersize(cond[2]), .isControl(cond[3]),
        .isOverrun(cond[4]), .isSymbolErr(cond[5]), .isAlignErr(cond[6]),
        .isChecksumErr(cond[7]), .isAddrMiss(cond[8]), .isJabber(cond[9]),
        .multiBuffer, .descWrite, .descStatus, .descFirst, .frameDiscarded);
    rxs_desc_mem i_mem (.sys_clk, .descWrite, .descStatus, .wrCount);
    // clock and discard counter
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (frameDiscarded === 1'b1) nDisc++;
    always @(posedge sys_clk)
        if (descWrite === 1'b1 && descFirst === 1'b1) nFirst++;
    task automatic chk(input rxs_status_t got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t status %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkn(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask : chkn
    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // one frame end report, then check the queue
    task automatic frame(input logic [9:0] c, input logic crc, mb,
                         input logic [3:0] k);
        logic [7:0] w0;
        int         d0, f0, t;
        logic       kept;
        w0 = wrCount;
        d0 = nDisc;
        f0 = nFirst;
        kept = c[4] | ((!(|(c & 10'h2E3)) | k[0]) & (!c[2] | k[1])
            & (!c[3] | k[2]) & (!c[8] | k[3]));
        @(posedge sys_clk) #5;
        {cond, checkRetained, multiBuffer, keepBits} = {c, crc, mb, k};
        frameDone = 1'b1;
        @(posedge sys_clk) #5;
        frameDone = 1'b0;
        for (t = 0; t < 8 && !(descWrite | frameDiscarded); t++)
            @(posedge sys_clk);
        if (t == 8) begin
            $display("BAD %0t no write and no discard", $time);
            n_mismatch++;
            stop_test();
        end
        repeat (4) @(posedge sys_clk);
        chkn(wrCount - w0, kept ? {6'h00, mb, !mb} : 8'h00);
        chkn(8'(nDisc - d0), {7'h00, !kept});
        chkn(8'(nFirst - f0), {7'h00, kept});
        if (kept) chk(i_mem.memWord[w0], {crc, c, !mb, 1'b1});
        if (kept && mb) chk(i_mem.memWord[w0 + 8'h01], 13'h0002);
    endtask : frame
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        #5 rst_b = 1'b1;
        for (int i = 0; i < 10; i++) frame(10'h001 << i, 1'b0, 1'b0, 4'hF);
        for (int i = 0; i < 10; i++) frame(10'h001 << i, 1'b0, 1'b0, 4'h0);
        frame(10'h000, 1'b1, 1'b0, 4'h0);
        frame(10'h2E3, 1'b1, 1'b1, 4'h1);
        frame(10'h013, 1'b0, 1'b1, 4'hB);
        frame(10'h104, 1'b0, 1'b0, 4'h7);
        frame(10'h100, 1'b0, 1'b1, 4'h8);
        stop_test();
    end
endmodule : rxs_writeback_test
bind rxs_writeback rxs_writeback_assertions i_chk (.sys_clk, .rst_b,
    .checkRetained, .keepErrorFrames, .keepShortFrames, .keepMacControlFrames,
    .keepAllFramesPromiscuous, .frameDone, .multiBuffer, .isOversize,
    .isFragment, .isUndersize, .isControl, .isOverrun, .isSymbolErr,
    .isAlignErr, .isChecksumErr, .isAddrMiss, .isJabber, .descWrite,
    .descFirst, .frameDiscarded, .descStatus);
